// >>> common/epv_map.vh
// Register map, field positions, reset values and vector addresses of the exception vectoring block
`ifndef EPV_MAP_VH
`define EPV_MAP_VH

// ****************************************************************
// Register byte offsets on the AHB-Lite bus
// ****************************************************************
`define EPV_OFS_CCR        8'h00
`define EPV_OFS_INTCTL     8'h04
`define EPV_OFS_TOP_PRIO   8'h08
`define EPV_OFS_VECTOR     8'h0c
`define EPV_OFS_PENDING    8'h10
`define EPV_OFS_IRQ_STATUS 8'h14
`define EPV_OFS_IRQ_MASK   8'h18
`define EPV_OFS_NMI_STATE  8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define EPV_CCR_I_BIT      4
`define EPV_CCR_X_BIT      6
`define EPV_CTL_CONNECT    0
`define EPV_CTL_EDGE       1
`define EPV_ST_TAKEN       0
`define EPV_ST_TRAP        1
`define EPV_ST_EDGE        2
`define EPV_ST_W           3

// ****************************************************************
// Reset values
// ****************************************************************
`define EPV_RST_I          1'b1
`define EPV_RST_X          1'b1
`define EPV_RST_CONNECT    1'b1
`define EPV_RST_EDGE       1'b0
`define EPV_RST_PRIO       8'hf2
`define EPV_RST_MASK       3'h0

// ****************************************************************
// Vector addresses, top page of the 64K map
// ****************************************************************
`define EPV_VEC_PAGE       8'hff
`define EPV_VEC_RESET      16'hfffe
`define EPV_VEC_CLKMON     16'hfffc
`define EPV_VEC_WDOG       16'hfffa
`define EPV_VEC_TRAP       16'hfff8
`define EPV_VEC_SWI        16'hfff6
`define EPV_VEC_NMI        16'hfff4
`define EPV_LOW_PIN        8'hf2

`endif

// >>> core/epv_core.v
// Exception arbitration and vectoring core with an AHB-Lite register slave
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "epv_map.vh"

// Contract
// - Every exception yields a 16-bit vector inside the top 128 bytes.
// - Six highest vectors serve resets and non-maskable sources; lower ones maskable.
// - Non-maskable order: reset, clock monitor, watchdog, trap, software op, masked pin.
// - Maskable requests count only while the global I mask bit is clear.
// - I bit is one after reset and writable at any time.
// - Default maskable order, one source raised to top, others keep order.
// - Promoted source still gated by I bit and its local enable.
// - Promotion never changes a source's vector address.
// - Top priority select accepts writes only while I bit is set.
// - Non-maskable pin is level sensitive; external pin may be level configured.
// - Servicing with no active request takes the trap vector.
// - Edge-configured pin latches a falling edge regardless of service timing.
// - Edge latch clears automatically when its interrupt is serviced.
// - Other sources are held by flags, which software clears in service.
// - Priority select takes vector low byte; invalid or above f2 selects pin.
// - Edge select: 0 low level, 1 falling edge; written once.
// - Pin connect bit disconnects pin at 0, connects at 1; writable anytime.
module epv_core
#(
  parameter NUM_PERIPH = 24,
  parameter IDXW       = 5
)
(
  input  wire                  hclk,
  input  wire                  hresetn,
  input  wire                  hsel,
  input  wire [7:0]            haddr,
  input  wire [1:0]            htrans,
  input  wire                  hwrite,
  input  wire [2:0]            hsize,
  input  wire [31:0]           hwdata,
  input  wire                  hready,
  output reg  [31:0]           hrdata,
  output reg                   hreadyout,
  output reg                   hresp,
  input  wire                  reset_req,
  input  wire                  clock_monitor_req,
  input  wire                  watchdog_reset,
  input  wire                  unimpl_trap_req,
  input  wire                  software_interrupt_op,
  input  wire                  nonmaskable_request_pin_n,
  input  wire                  ext_request_pin_n,
  input  wire [NUM_PERIPH-1:0] periph_flag,
  input  wire [NUM_PERIPH-1:0] periph_enable,
  input  wire                  take_req,
  output reg                   exception_pending,
  output reg  [15:0]           vector_addr,
  output reg                   vector_valid,
  output reg                   irq
);

  localparam NSRC = NUM_PERIPH + 1;

  // ****************************************************************
  // Bus slave state
  // ****************************************************************
  reg        wr_pend;
  reg        rd_pend;
  reg [7:0]  ph_addr;
  wire       addr_ok = hsel & htrans[1] & hready;

  // ****************************************************************
  // Control and status registers
  // ****************************************************************
  reg                  ibit;
  reg                  xbit;
  reg                  pin_connect_bit;
  reg                  edge_select_bit;
  reg                  edge_lock;
  reg [7:0]            top_priority_select;
  reg [`EPV_ST_W-1:0]  irq_status;
  reg [`EPV_ST_W-1:0]  irq_mask;
  reg [15:0]           last_vector;

  // ****************************************************************
  // Pin synchronisers and edge latch
  // ****************************************************************
  reg        nmi_s1;
  reg        nmi_s2;
  reg        ext_s1;
  reg        ext_s2;
  reg        ext_s3;
  reg        edge_latch;

  // Two-stage synchronisers, plus a delay stage for edge detection
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end
    else
    begin
      nmi_s1 <= nonmaskable_request_pin_n;
      nmi_s2 <= nmi_s1;
      ext_s1 <= ext_request_pin_n;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Falling edge seen only once it has held through both stages
  wire ext_fall = ext_s3 & ~ext_s2;

  // Pin request: latch in edge mode, low level otherwise
  wire pin_req = pin_connect_bit & (edge_select_bit ? edge_latch : ~ext_s2);

  // Non-maskable pin is always a level, gated by the X bit
  wire nmi_req = ~nmi_s2 & ~xbit;

  // ****************************************************************
  // Maskable request vector, index 0 is the external pin
  // ****************************************************************
  wire [NSRC-1:0] mreq;
  assign mreq[0] = pin_req;

  // Each peripheral request is its flag gated by its local enable
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g = g + 1)
    begin : gen_req
      assign mreq[g+1] = periph_flag[g] & periph_enable[g];
    end
  endgenerate

  // Decode the promoted index from the stored vector low byte
  wire [7:0] prio_diff = `EPV_LOW_PIN - top_priority_select;
  wire       prio_ok   = ~top_priority_select[0] & (top_priority_select <= `EPV_LOW_PIN)
                         & ({1'b0, prio_diff[7:1]} < NSRC);
  wire [IDXW-1:0] promo_idx = prio_ok ? prio_diff[IDXW:1] : {IDXW{1'b0}};

  // ****************************************************************
  // Arbitration, recomputed every cycle
  // ****************************************************************
  reg [IDXW-1:0] sel_idx;
  reg [15:0]     win_vec;
  reg            win_trap;
  reg            win_pin;
  reg            win_nmi;
  reg            any_req;
  integer        i;

  // Default order is lowest index first; the promoted source beats it
  always @*
  begin
    sel_idx = {IDXW{1'b0}};
    for (i = NSRC - 1; i >= 0; i = i - 1)
    begin
      if (mreq[i])
        sel_idx = i[IDXW-1:0];
    end
    if (mreq[promo_idx])
      sel_idx = promo_idx;
  end

  // Fixed non-maskable order, then maskable, else the trap vector
  always @*
  begin
    win_vec  = `EPV_VEC_TRAP;
    win_trap = 1'b0;
    win_pin  = 1'b0;
    win_nmi  = 1'b0;
    any_req  = 1'b1;
    if (reset_req)
      win_vec = `EPV_VEC_RESET;
    else if (clock_monitor_req)
      win_vec = `EPV_VEC_CLKMON;
    else if (watchdog_reset)
      win_vec = `EPV_VEC_WDOG;
    else if (unimpl_trap_req)
      win_vec = `EPV_VEC_TRAP;
    else if (software_interrupt_op)
      win_vec = `EPV_VEC_SWI;
    else if (nmi_req)
    begin
      win_vec = `EPV_VEC_NMI;
      win_nmi = 1'b1;
    end
    else if (~ibit & (|mreq))
    begin
      // Vector is fixed per source, independent of promotion
      win_vec = {`EPV_VEC_PAGE, `EPV_LOW_PIN - {2'b00, sel_idx, 1'b0}};
      win_pin = (sel_idx == {IDXW{1'b0}});
    end
    else
    begin
      win_trap = 1'b1;
      any_req  = 1'b0;
    end
  end

  // ****************************************************************
  // Core handshake: pending level and vector on take
  // ****************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      exception_pending <= 1'b0;
      vector_addr       <= `EPV_VEC_RESET;
      vector_valid      <= 1'b0;
      last_vector       <= `EPV_VEC_RESET;
    end
    else
    begin
      exception_pending <= any_req;
      vector_valid      <= take_req;
      if (take_req)
      begin
        vector_addr <= win_vec;
        last_vector <= win_vec;
      end
    end
  end

  // Edge latch: set wins over the automatic clear on service
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      edge_latch <= 1'b0;
    else if (ext_fall & edge_select_bit & pin_connect_bit)
      edge_latch <= 1'b1;
    else if (take_req & win_pin)
      edge_latch <= 1'b0;
  end

  // ****************************************************************
  // AHB-Lite slave: writes zero wait, reads one wait state
  // ****************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      ph_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_ok & hwrite;
      if (addr_ok)
        ph_addr <= {haddr[7:2], 2'b00};
      if (addr_ok & ~hwrite)
      begin
        rd_pend   <= 1'b1;
        hreadyout <= 1'b0;
      end
      else if (rd_pend)
      begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // Read data multiplexer, loaded in the wait state
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h00000000;
    case (ph_addr)
      `EPV_OFS_CCR:
      begin
        rd_mux[`EPV_CCR_I_BIT] = ibit;
        rd_mux[`EPV_CCR_X_BIT] = xbit;
      end
      `EPV_OFS_INTCTL:
      begin
        rd_mux[`EPV_CTL_CONNECT] = pin_connect_bit;
        rd_mux[`EPV_CTL_EDGE]    = edge_select_bit;
      end
      `EPV_OFS_TOP_PRIO:   rd_mux[7:0] = top_priority_select;
      `EPV_OFS_VECTOR:     rd_mux[15:0] = last_vector;
      `EPV_OFS_PENDING:    rd_mux[NSRC-1:0] = mreq;
      `EPV_OFS_IRQ_STATUS: rd_mux[`EPV_ST_W-1:0] = irq_status;
      `EPV_OFS_IRQ_MASK:   rd_mux[`EPV_ST_W-1:0] = irq_mask;
      `EPV_OFS_NMI_STATE:  rd_mux[5:0] = {~nmi_s2, software_interrupt_op, unimpl_trap_req,
                                          watchdog_reset, clock_monitor_req, reset_req};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  // Read data register
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_pend)
      hrdata <= rd_mux;
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  wire wr_ccr  = wr_pend & (ph_addr == `EPV_OFS_CCR);
  wire wr_ctl  = wr_pend & (ph_addr == `EPV_OFS_INTCTL);
  wire wr_prio = wr_pend & (ph_addr == `EPV_OFS_TOP_PRIO);
  wire wr_st   = wr_pend & (ph_addr == `EPV_OFS_IRQ_STATUS);
  wire wr_msk  = wr_pend & (ph_addr == `EPV_OFS_IRQ_MASK);

  // Mask bits: take sets I (and X for the pin), else software write
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ibit <= `EPV_RST_I;
      xbit <= `EPV_RST_X;
    end
    else
    begin
      if (take_req)
        ibit <= 1'b1;
      else if (wr_ccr)
        ibit <= hwdata[`EPV_CCR_I_BIT];
      if (take_req & win_nmi)
        xbit <= 1'b1;
      else if (wr_ccr & ~hwdata[`EPV_CCR_X_BIT])
        xbit <= 1'b0;                                          // Software may only clear X
    end
  end

  // Pin control: connect anytime, edge select written once
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_connect_bit <= `EPV_RST_CONNECT;
      edge_select_bit <= `EPV_RST_EDGE;
      edge_lock       <= 1'b0;
    end
    else if (wr_ctl)
    begin
      pin_connect_bit <= hwdata[`EPV_CTL_CONNECT];
      if (~edge_lock)
      begin
        edge_select_bit <= hwdata[`EPV_CTL_EDGE];
        edge_lock       <= 1'b1;
      end
    end
  end

  // Top priority select: ignored while maskable interrupts are enabled
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      top_priority_select <= `EPV_RST_PRIO;
    else if (wr_prio & ibit)
      top_priority_select <= hwdata[7:0];
  end

  // ****************************************************************
  // Event interrupt: sticky status, mask, level output
  // ****************************************************************
  wire [`EPV_ST_W-1:0] ev;
  assign ev[`EPV_ST_TAKEN] = take_req & ~win_trap;
  assign ev[`EPV_ST_TRAP]  = take_req & win_trap;
  assign ev[`EPV_ST_EDGE]  = ext_fall & edge_select_bit & pin_connect_bit;

  // Write one clears; a new event in the same cycle wins
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status <= {`EPV_ST_W{1'b0}};
      irq_mask   <= `EPV_RST_MASK;
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= ev | (irq_status & ~(wr_st ? hwdata[`EPV_ST_W-1:0] : {`EPV_ST_W{1'b0}}));
      if (wr_msk)
        irq_mask <= hwdata[`EPV_ST_W-1:0];
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

// >>> tb/epv_chk.sv
// Assertion checker for the exception vectoring core
`timescale 1ns/1ps
// ****************************************************************
// Checker
// ****************************************************************
module epv_chk
#(
  parameter NUM_PERIPH = 24,
  parameter IDXW       = 5
)
(
  input wire        hclk,
  input wire        hresetn,
  input wire        reset_req,
  input wire        clock_monitor_req,
  input wire        watchdog_reset,
  input wire        unimpl_trap_req,
  input wire        software_interrupt_op,
  input wire        take_req,
  input wire        exception_pending,
  input wire [15:0] vector_addr,
  input wire        vector_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Non-maskable requests, highest first
  wire [4:0] nm = {reset_req, clock_monitor_req, watchdog_reset, unimpl_trap_req, software_interrupt_op};
  a_take_answer: assert property (take_req |=> vector_valid)
    else $error("no vector after take");
  a_valid_pulse: assert property (!take_req |=> !vector_valid)
    else $error("vector valid without take");
  a_vector_page: assert property (vector_valid |-> vector_addr[15:7] == 9'h1ff && !vector_addr[0])
    else $error("vector outside top page");
  a_reset_first: assert property (take_req && nm[4] |=> vector_addr == 16'hfffe)
    else $error("reset not first");
  a_clkmon_next: assert property (take_req && nm[4:3] == 2'b01 |=> vector_addr == 16'hfffc)
    else $error("clock monitor order");
  a_wdog_next: assert property (take_req && nm[4:2] == 3'b001 |=> vector_addr == 16'hfffa)
    else $error("watchdog order");
  a_trap_next: assert property (take_req && nm[4:1] == 4'b0001 |=> vector_addr == 16'hfff8)
    else $error("trap order");
  a_swi_next: assert property (take_req && nm == 5'b00001 |=> vector_addr == 16'hfff6)
    else $error("software op order");
  a_nm_pending: assert property (|nm |=> exception_pending)
    else $error("non-maskable request not pending");
  a_maskable_low: assert property (vector_valid && vector_addr < 16'hfff4 |-> vector_addr[7:0] <= 8'hf2)
    else $error("maskable vector in reserved range");
  c_trap: cover property (take_req && nm == 5'h0 ##1 vector_addr == 16'hfff8);
  c_pin: cover property (vector_valid && vector_addr == 16'hfff2);
  c_promoted: cover property (vector_valid && vector_addr == 16'hffee);
endmodule

bind epv_core epv_chk #(.NUM_PERIPH(NUM_PERIPH), .IDXW(IDXW)) chk_i (
  .hclk(hclk), .hresetn(hresetn), .reset_req(reset_req), .clock_monitor_req(clock_monitor_req),
  .watchdog_reset(watchdog_reset), .unimpl_trap_req(unimpl_trap_req),
  .software_interrupt_op(software_interrupt_op), .take_req(take_req),
  .exception_pending(exception_pending), .vector_addr(vector_addr), .vector_valid(vector_valid));

// >>> tb/epv_src_model.sv
// Partner model: the core taking exceptions and the request sources
`timescale 1ns/1ps
module epv_src_model
#(
  parameter NUM_PERIPH = 24
)
(
  input  wire                  hclk,
  input  wire [15:0]           vector_addr,
  input  wire                  vector_valid,
  output reg                   take_req,
  output reg                   ext_request_pin_n,
  output reg                   nonmaskable_request_pin_n,
  output reg  [NUM_PERIPH-1:0] periph_flag
);
  // Idle sources, pins pulled up
  initial
  begin
    take_req = 1'b0;
    ext_request_pin_n = 1'b1;
    nonmaskable_request_pin_n = 1'b1;
    periph_flag = {NUM_PERIPH{1'b0}};
  end
  // One take pulse, vector read when it stands
  task take(output [15:0] v);
  begin
    @(posedge hclk);
    take_req <= 1'b1;
    @(posedge hclk);
    take_req <= 1'b0;
    @(posedge hclk);
    v = vector_addr;
  end
  endtask
  task set_flag(input integer k, input val);
  begin
    @(posedge hclk);
    periph_flag[k] <= val;
  end
  endtask
  task drive_ext(input val);
  begin
    @(posedge hclk);
    ext_request_pin_n <= val;
  end
  endtask
  task drive_nmi(input val);
  begin
    @(posedge hclk);
    nonmaskable_request_pin_n <= val;
  end
  endtask
  // Service routine releases its pin or clears its flag
  always @(posedge hclk)
  begin
    if (vector_valid === 1'b1 && vector_addr == 16'hfff2)
      ext_request_pin_n <= 1'b1;
    if (vector_valid === 1'b1 && vector_addr == 16'hfff4)
      nonmaskable_request_pin_n <= 1'b1;
    if (vector_valid === 1'b1 && vector_addr < 16'hfff2)
      periph_flag[(8'hf0 - vector_addr[7:0]) >> 1] <= 1'b0;
  end
endmodule

// >>> tb/tb_exception_priority_vectoring.sv
// Self-checking testbench for the exception vectoring core
`timescale 1ns/1ps
`include "epv_map.vh"
module tb_exception_priority_vectoring;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [7:0]  haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg  [2:0]  hsize;
  reg  [4:0]  nm;
  reg  [23:0] pen;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        take_req;
  wire        ext_n;
  wire        nmi_n;
  wire [23:0] pflag;
  wire [15:0] vector_addr;
  wire        vector_valid;
  wire        irq;
  wire        pend;
  wire        hresp;
  integer     failures;
  integer     check_count;
  integer     i;
  reg  [31:0] rv;
  reg  [15:0] v;
  epv_core #(.NUM_PERIPH(24), .IDXW(5)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reset_req(nm[4]), .clock_monitor_req(nm[3]), .watchdog_reset(nm[2]),
    .unimpl_trap_req(nm[1]), .software_interrupt_op(nm[0]), .nonmaskable_request_pin_n(nmi_n),
    .ext_request_pin_n(ext_n), .periph_flag(pflag), .periph_enable(pen), .take_req(take_req),
    .exception_pending(pend), .vector_addr(vector_addr), .vector_valid(vector_valid), .irq(irq));
  epv_src_model #(.NUM_PERIPH(24)) m (
    .hclk(hclk), .vector_addr(vector_addr), .vector_valid(vector_valid), .take_req(take_req),
    .ext_request_pin_n(ext_n), .nonmaskable_request_pin_n(nmi_n), .periph_flag(pflag));
  // ****************************************************************
  // Clock, tasks and watchdog
  // ****************************************************************
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Single AHB-Lite transfer, address then data phase
  task bus(input [7:0] a, input w, input [31:0] d, output [31:0] r);
  begin
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task idle(input integer n);
  begin
    repeat (n) @(posedge hclk);
  end
  endtask
  // Optionally unmask, take an exception, compare its vector
  task svc(input clr, input [15:0] exp);
  begin
    if (clr)
      bus(`EPV_OFS_CCR, 1'b1, 32'h0, rv);
    m.take(v);
    chk({16'h0, v}, {16'h0, exp});
  end
  endtask
  task end_of_test;
  begin
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  initial
  begin
    #(5000 * 100);
    failures = failures + 1;
    end_of_test;
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    failures = 0;
    check_count = 0;
    hsel = 1'b0;
    haddr = 8'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hsize = 3'b010;
    nm = 5'h0;
    pen = 24'h0;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, pend}, 32'h0);
    // Reset values, unmapped place, global mask writable
    bus(`EPV_OFS_CCR, 1'b0, 32'h0, rv);
    chk(rv & 32'h50, 32'h50);
    bus(`EPV_OFS_INTCTL, 1'b0, 32'h0, rv);
    chk(rv, 32'h1);
    bus(8'h20, 1'b0, 32'h0, rv);
    chk(rv, 32'h0);
    bus(`EPV_OFS_CCR, 1'b1, 32'h0, rv);
    bus(`EPV_OFS_CCR, 1'b0, 32'h0, rv);
    chk(rv & 32'h10, 32'h0);
    // Priority select gated by the global mask
    bus(`EPV_OFS_TOP_PRIO, 1'b1, 32'hee, rv);
    bus(`EPV_OFS_TOP_PRIO, 1'b0, 32'h0, rv);
    chk(rv, 32'hf2);
    bus(`EPV_OFS_CCR, 1'b1, 32'h10, rv);
    bus(`EPV_OFS_TOP_PRIO, 1'b1, 32'hee, rv);
    bus(`EPV_OFS_TOP_PRIO, 1'b0, 32'h0, rv);
    chk(rv, 32'hee);
    // Maskable ordering, promotion and local enables
    pen <= 24'h3;
    m.set_flag(0, 1'b1);
    m.set_flag(1, 1'b1);
    idle(2);
    bus(`EPV_OFS_PENDING, 1'b0, 32'h0, rv);
    chk(rv, 32'h6);
    chk({31'h0, pend}, 32'h0);
    svc(1'b0, 16'hfff8);
    svc(1'b1, 16'hffee);
    svc(1'b1, 16'hfff0);
    pen <= 24'h1;
    m.set_flag(0, 1'b1);
    m.set_flag(1, 1'b1);
    idle(2);
    svc(1'b1, 16'hfff0);
    pen <= 24'h3;
    bus(`EPV_OFS_TOP_PRIO, 1'b1, 32'hef, rv);
    m.set_flag(0, 1'b1);
    idle(2);
    svc(1'b1, 16'hfff0);
    svc(1'b1, 16'hffee);
    pen <= 24'h0;
    // Level pin, then spurious service after release
    m.drive_ext(1'b0);
    idle(5);
    svc(1'b1, 16'hfff2);
    idle(5);
    svc(1'b1, 16'hfff8);
    // Edge mode: latch a short pulse, cleared by service
    bus(`EPV_OFS_INTCTL, 1'b1, 32'h3, rv);
    m.drive_ext(1'b0);
    idle(4);
    m.drive_ext(1'b1);
    idle(6);
    svc(1'b1, 16'hfff2);
    svc(1'b1, 16'hfff8);
    // Edge select locked, pin disconnected
    bus(`EPV_OFS_INTCTL, 1'b1, 32'h0, rv);
    bus(`EPV_OFS_INTCTL, 1'b0, 32'h0, rv);
    chk(rv, 32'h2);
    m.drive_ext(1'b0);
    idle(4);
    m.drive_ext(1'b1);
    idle(6);
    svc(1'b1, 16'hfff8);
    // Non-maskable order, one source withdrawn per service
    bus(`EPV_OFS_CCR, 1'b1, 32'h10, rv);
    nm <= 5'h1f;
    m.drive_nmi(1'b0);
    idle(5);
    chk({31'h0, pend}, 32'h1);
    bus(`EPV_OFS_NMI_STATE, 1'b0, 32'h0, rv);
    chk(rv, 32'h3f);
    for (i = 0; i < 6; i = i + 1)
    begin
      svc(1'b0, 16'hfffe - 2 * i);
      if (i < 5)
        nm[4 - i] <= 1'b0;
    end
    // Pin blocked once the X bit is set by its own take
    m.drive_nmi(1'b0);
    idle(5);
    svc(1'b0, 16'hfff8);
    m.drive_nmi(1'b1);
    // Interrupt status raised, masked and cleared
    bus(`EPV_OFS_IRQ_MASK, 1'b1, 32'h2, rv);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    bus(`EPV_OFS_IRQ_STATUS, 1'b1, 32'h7, rv);
    bus(`EPV_OFS_IRQ_MASK, 1'b1, 32'h0, rv);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    svc(1'b1, 16'hfff8);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    bus(`EPV_OFS_IRQ_STATUS, 1'b0, 32'h0, rv);
    chk(rv, 32'h2);
    chk({31'h0, hresp}, 32'h0);
    bus(`EPV_OFS_VECTOR, 1'b0, 32'h0, rv);
    chk(rv, 32'hfff8);
    end_of_test;
  end
endmodule
